// >>> logic/pwm_dim_pkg.sv
/*
  Constants shared by the multichannel PWM dimming unit: frame layout,
  register addresses, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 16-bit frame word per command.
*/
package pwm_dim_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CH   = 6;                  // Five power outputs plus external channel
  localparam int NUM_INT  = 5;                  // Internal channels (skip and step capable)
  localparam int NUM_PIN  = 4;                  // Channels with a control pin
  localparam int BASE_W   = 13;                 // Free running period counter width

  // ****************************************************************
  // Frame addresses (upper nibble of the frame word)
  // ****************************************************************
  localparam logic [3:0] ADDR_INIT     = 4'h1;
  localparam logic [3:0] ADDR_CH_FIRST = 4'h2;
  localparam logic [3:0] ADDR_CH_LAST  = 4'h7;
  localparam logic [3:0] ADDR_OUT_CTRL = 4'h8;
  localparam logic [3:0] ADDR_GLOBAL   = 4'h9;
  localparam logic [3:0] ADDR_IN_EN    = 4'hb;
  localparam logic [3:0] ADDR_PRESCALE = 4'hc;
  localparam logic [3:0] ADDR_INCR     = 4'he;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FRM_ADDR_LSB   = 12;
  localparam int CH_ALIVE_BIT   = 11;           // host_alive_toggle, not used here
  localparam int CH_PHASE_LSB   = 9;            // phase_select_low, high at +1
  localparam int CH_ON_BIT      = 8;
  localparam int INIT_SYNC_BIT  = 1;
  localparam int OUT_ON_LSB     = 0;            // Six on bits
  localparam int OUT_SKIP_LSB   = 6;            // Five skip enables
  localparam int GLOBAL_SUB_BIT = 8;            // 0: select word, 1: shared duty
  localparam int GSEL_LSB       = 0;
  localparam int IN_EN_LSB      = 0;            // Two bits per pin channel
  localparam int PRESCALE_LSB   = 0;            // Two bits per channel
  localparam int INCR_DIR_BIT   = 10;
  localparam int INCR_STEP_LSB  = 0;            // Two bits per internal channel

  // ****************************************************************
  // Reset values and duty codes
  // ****************************************************************
  localparam logic [7:0] DUTY_RST      = 8'h00;
  localparam logic [1:0] PHASE_RST     = 2'h0;
  localparam logic [1:0] PRESCALE_RST  = 2'h0;
  localparam logic [1:0] IN_EN_RST     = 2'h0;
  localparam logic [7:0] DUTY_FULL     = 8'hff;
  localparam logic [7:0] DUTY_SKIP_LOW = 8'hf7;
  localparam logic [7:0] DUTY_SKIP_MIN = 8'hf8;
  localparam logic [7:0] STEP_SMALL    = 8'h04;
  localparam logic [7:0] STEP_MID      = 8'h08;
  localparam logic [7:0] STEP_LARGE    = 8'h10;

  // ****************************************************************
  // Reference clock supervision
  // ****************************************************************
  localparam int SYS_CLK_HZ      = 100_000_000;
  localparam int REF_MIN_HZ      = 25_600;
  localparam int REF_MAX_HZ      = 102_400;
  localparam int REF_SLOW_CYCLES = 2 * (SYS_CLK_HZ / REF_MIN_HZ); // Edge gap counted as lost
  localparam int REF_FAST_CYCLES = SYS_CLK_HZ / REF_MAX_HZ / 2;   // Shorter gap means too fast

endpackage

// >>> logic/pwm_channel_engine.sv
/*
  One PWM channel: derives its count from the shared period counter,
  applies divider and phase, holds the active on state and duty, and
  interpolates codes F8..FE by pulse skipping.
  Assumes base_count_in advances once per reference tick on clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_engine
  import pwm_dim_pkg::*;
(
  input  wire logic              clk_sys_in,       // System clock
  input  wire logic              rst_in,           // Async reset, high
  input  wire logic [BASE_W-1:0] base_count_in,    // Shared period counter
  input  wire logic [1:0]        divider_sel_in,   // divider_select_high/low
  input  wire logic [1:0]        phase_in,         // phase_select_high/low
  input  wire logic              state_in,         // channel_state request
  input  wire logic [7:0]        duty_in,          // Selected duty code
  input  wire logic              skip_en_in,       // skip_interpolation_enable
  input  wire logic              bypass_in,        // No modulation, follow state
  output logic                   power_output_out, // Modulated output
  output logic                   window_start_out  // Rising channel state pulse
);

  // ****************************************************************
  // Count position
  // ****************************************************************
  logic [10:0] shifted;
  logic [10:0] pos;
  logic [7:0]  cnt;
  logic [2:0]  slot;
  logic [7:0]  cnt_prev_r;
  logic        period_start;
  logic        immediate;
  logic        act_on_r;
  logic [7:0]  act_duty_r;
  logic [7:0]  eff_duty;
  logic        state_prev_r;

  // Rank of a slot in the skip order is its bit reversal
  function automatic logic [7:0] skip_duty(input logic [7:0] duty, input logic [2:0] s, input logic en);
    logic [2:0] rank;
    logic [2:0] need;
    rank = {s[0], s[1], s[2]};
    need = 3'(DUTY_FULL - duty);
    if (en && duty >= DUTY_SKIP_MIN && duty != DUTY_FULL && rank < need)
      skip_duty = DUTY_SKIP_LOW;
    else
      skip_duty = duty;
  endfunction

  // Divider picks which counter bits form the period; upper bit wins
  always_comb begin
    if (divider_sel_in[1])
      shifted = base_count_in[10:0];
    else if (divider_sel_in[0])
      shifted = base_count_in[11:1];
    else
      shifted = base_count_in[12:2];                 // Longest period, widest range
    pos  = shifted + {3'b000, phase_in, 6'h00};      // Quarter period per phase step
    cnt  = pos[7:0];
    slot = pos[10:8];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      cnt_prev_r <= 8'h00;
    else
      cnt_prev_r <= cnt;
  end

  assign period_start = (cnt == 8'h00) && (cnt_prev_r != 8'h00);

  // ****************************************************************
  // Active settings
  // ****************************************************************
  // Off and full duty act at once; lower duty waits for the period
  assign immediate = !state_in || (duty_in == DUTY_FULL);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      act_on_r   <= 1'b0;
      act_duty_r <= DUTY_RST;
    end else if (immediate || period_start) begin
      act_on_r   <= state_in;
      act_duty_r <= duty_in;
    end
  end

  assign eff_duty = skip_duty(act_duty_r, slot, skip_en_in);

  // On for counts 0..code, so FF is steady on
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      power_output_out <= 1'b0;
    else if (bypass_in)
      power_output_out <= state_in;
    else
      power_output_out <= act_on_r && (cnt <= eff_duty);
  end

  // Window start marks each rise of the channel state
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_prev_r     <= 1'b0;
      window_start_out <= 1'b0;
    end else begin
      state_prev_r     <= state_in;
      window_start_out <= state_in && !state_prev_r;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_off_now;
    @(posedge clk_sys_in) disable iff (rst_in)
    !state_in ##1 !state_in |=> !power_output_out;
  endproperty
  a_off_now: assert property (p_off_now) else $error("output stayed on after switch off");

  property p_bypass_full;
    @(posedge clk_sys_in) disable iff (rst_in)
    bypass_in && state_in |=> power_output_out;
  endproperty
  a_bypass_full: assert property (p_bypass_full) else $error("bypass did not give full on");

  sequence s_rise_low;
    $rose(state_in) && duty_in != DUTY_FULL && !period_start;
  endsequence
  property p_defer_on;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_rise_low |=> !act_on_r;
  endproperty
  a_defer_on: assert property (p_defer_on) else $error("low duty switch on not deferred");

  property p_full_on;
    @(posedge clk_sys_in) disable iff (rst_in)
    state_in && duty_in == DUTY_FULL ##1 state_in |=> power_output_out;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty not steady on");

endmodule

`default_nettype wire

// >>> logic/pwm_dimming_unit.sv
/*
  Multichannel PWM dimming unit: takes 16-bit command frames from the
  serial front end, keeps the channel settings, supervises the reference
  clock and drives six PWM channels.
  Assumes the serial front end hands over each complete frame with a
  one-cycle strobe on its own clock at the frame end, and frames are
  spaced by at least 1 us.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_dimming_unit
  import pwm_dim_pkg::*;
#(
  parameter int SLOW_CYCLES = REF_SLOW_CYCLES   // Edge gap treated as clock loss
) (
  input  wire logic               clk_sys_in,               // System clock, 100 MHz
  input  wire logic               rst_in,                   // Async reset, high
  input  wire logic               clk_link_in,              // Serial front end clock
  input  wire logic [15:0]        frame_word_in,            // Complete frame word
  input  wire logic               frame_done_in,            // Frame end strobe, link clock
  input  wire logic               ref_clock_in,             // Reference clock pin
  input  wire logic               fail_mode_in,             // Device in fail mode
  input  wire logic [NUM_PIN-1:0] filtered_control_pin_in,  // Deglitched control pins
  output logic [NUM_CH-1:0]       power_output_out,         // Channel drive
  output logic [NUM_INT-1:0]      window_start_out,         // Overcurrent window start
  output logic [NUM_CH-1:0]       channel_state_out,        // Channel on state
  output logic                    ref_clock_fail_out        // Reference clock failed
);

  // ****************************************************************
  // Frame hand-over from the link clock
  // ****************************************************************
  logic [15:0] link_word_r;
  logic        link_toggle_r;
  logic        tog_s1_r;
  logic        tog_s2_r;
  logic        tog_s3_r;
  logic        commit;
  logic [3:0]  frame_addr;

  // Word held steady until the next frame; spacing covers the crossing
  always_ff @(posedge clk_link_in or posedge rst_in) begin
    if (rst_in) begin
      link_word_r   <= 16'h0000;
      link_toggle_r <= 1'b0;
    end else if (frame_done_in) begin
      link_word_r   <= frame_word_in;
      link_toggle_r <= !link_toggle_r;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      tog_s1_r <= link_toggle_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  assign commit     = tog_s2_r ^ tog_s3_r;
  assign frame_addr = link_word_r[FRM_ADDR_LSB +: 4];

  // ****************************************************************
  // Settings
  // ****************************************************************
  logic [7:0] duty_r [NUM_CH];
  logic [1:0] phase_r [NUM_CH];
  logic [1:0] prescale_r [NUM_CH];
  logic [1:0] in_en_r [NUM_PIN];
  logic [NUM_CH-1:0]  on_r;
  logic [NUM_CH-1:0]  gsel_r;
  logic [NUM_INT-1:0] skip_r;
  logic [7:0]         gduty_r;

  // Saturating step of one duty value
  function automatic logic [7:0] step_duty(input logic [7:0] duty, input logic [1:0] code, input logic up);
    logic [7:0] step;
    logic [8:0] sum;
    case (code)
      2'b01:   step = STEP_SMALL;
      2'b10:   step = STEP_MID;
      2'b11:   step = STEP_LARGE;
      default: step = 8'h00;
    endcase
    sum = {1'b0, duty} + {1'b0, step};
    if (up)
      step_duty = sum[8] ? DUTY_FULL : sum[7:0];
    else
      step_duty = (duty < step) ? 8'h00 : duty - step;
  endfunction

  // Own duty: channel word, or step frame for internal channels
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++)
        duty_r[i] <= DUTY_RST;
    end else if (commit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (frame_addr == 4'(ADDR_CH_FIRST + i))
          duty_r[i] <= link_word_r[7:0];
        else if (frame_addr == ADDR_INCR && i < NUM_INT)
          duty_r[i] <= step_duty(duty_r[i], link_word_r[INCR_STEP_LSB + 2*i +: 2],
                                 link_word_r[INCR_DIR_BIT]);
      end
    end
  end

  // Phase and on bits from channel words; on bits also from register 8
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      on_r <= '0;
      for (int i = 0; i < NUM_CH; i++)
        phase_r[i] <= PHASE_RST;
    end else if (commit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (frame_addr == 4'(ADDR_CH_FIRST + i)) begin
          phase_r[i] <= link_word_r[CH_PHASE_LSB +: 2];
          on_r[i]    <= link_word_r[CH_ON_BIT];
        end
      end
      if (frame_addr == ADDR_OUT_CTRL)
        on_r <= link_word_r[OUT_ON_LSB +: NUM_CH];
    end
  end

  // Skip enables, shared select and shared duty
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      skip_r  <= '0;
      gsel_r  <= '0;
      gduty_r <= DUTY_RST;
    end else if (commit) begin
      if (frame_addr == ADDR_OUT_CTRL)
        skip_r <= link_word_r[OUT_SKIP_LSB +: NUM_INT];
      if (frame_addr == ADDR_GLOBAL && !link_word_r[GLOBAL_SUB_BIT])
        gsel_r <= link_word_r[GSEL_LSB +: NUM_CH];
      if (frame_addr == ADDR_GLOBAL && link_word_r[GLOBAL_SUB_BIT])
        gduty_r <= link_word_r[7:0];
    end
  end

  // Divider selects and pin gate bits
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++)
        prescale_r[i] <= PRESCALE_RST;
      for (int i = 0; i < NUM_PIN; i++)
        in_en_r[i] <= IN_EN_RST;
    end else if (commit) begin
      for (int i = 0; i < NUM_CH; i++)
        if (frame_addr == ADDR_PRESCALE)
          prescale_r[i] <= link_word_r[PRESCALE_LSB + 2*i +: 2];
      for (int i = 0; i < NUM_PIN; i++)
        if (frame_addr == ADDR_IN_EN)
          in_en_r[i] <= link_word_r[IN_EN_LSB + 2*i +: 2];
    end
  end

  // ****************************************************************
  // Reference clock: sampling, supervision, period counter
  // ****************************************************************
  logic              ref_s1_r;
  logic              ref_s2_r;
  logic              ref_s3_r;
  logic              ref_tick;
  logic [15:0]       gap_r;
  logic              sync_cmd;
  logic [BASE_W-1:0] base_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_clock_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign ref_tick = ref_s2_r && !ref_s3_r;

  // Gap between edges judges the clock; loss is flagged without waiting
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r              <= 16'h0000;
      ref_clock_fail_out <= 1'b0;
    end else if (ref_tick) begin
      gap_r              <= 16'h0000;
      ref_clock_fail_out <= gap_r < 16'(REF_FAST_CYCLES);
    end else begin
      if (gap_r != 16'hffff)
        gap_r <= gap_r + 16'h0001;
      if (gap_r >= 16'(SLOW_CYCLES))
        ref_clock_fail_out <= 1'b1;
    end
  end

  assign sync_cmd = commit && frame_addr == ADDR_INIT && link_word_r[INIT_SYNC_BIT];

  // One count per reference edge; sync clears at the frame end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      base_r <= '0;
    else if (sync_cmd)
      base_r <= '0;
    else if (ref_tick)
      base_r <= base_r + 1'b1;
  end

  // ****************************************************************
  // Channel state, duty source and engines
  // ****************************************************************
  logic [7:0] sel_duty [NUM_CH];
  logic       bypass;

  assign bypass = fail_mode_in || ref_clock_fail_out;

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic use_global;
      logic chan_state;
      if (c < NUM_PIN) begin : g_pin
        logic pin;
        assign pin = filtered_control_pin_in[c];
        // Gate 01/10 needs the pin; 11 lets the pin swap duty source
        always_comb begin
          if (fail_mode_in)
            chan_state = pin;
          else if (in_en_r[c] == 2'b01 || in_en_r[c] == 2'b10)
            chan_state = on_r[c] && pin;
          else
            chan_state = on_r[c];
          use_global = (in_en_r[c] == 2'b11) ? gsel_r[c] ^ pin : gsel_r[c];
        end
      end else begin : g_plain
        assign chan_state = on_r[c] && !fail_mode_in;
        assign use_global = gsel_r[c];
      end
      // One local driver per channel keeps the state vector single-sourced
      assign channel_state_out[c] = chan_state;
      assign sel_duty[c] = use_global ? gduty_r : duty_r[c];

      logic ws;
      pwm_channel_engine u_engine (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .base_count_in    (base_r),
        .divider_sel_in   (prescale_r[c]),
        .phase_in         (phase_r[c]),
        .state_in         (channel_state_out[c]),
        .duty_in          (sel_duty[c]),
        .skip_en_in       (c < NUM_INT ? skip_r[c % NUM_INT] : 1'b0),
        .bypass_in        (bypass),
        .power_output_out (power_output_out[c]),
        .window_start_out (ws)
      );
      if (c < NUM_INT) begin : g_ws
        assign window_start_out[c] = ws;
      end
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_sync_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    sync_cmd |=> base_r == '0;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear counter");

  property p_step_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    commit && frame_addr == ADDR_INCR && link_word_r[INCR_DIR_BIT] |=> duty_r[0] >= $past(duty_r[0]);
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up wrapped");

  property p_step_down;
    @(posedge clk_sys_in) disable iff (rst_in)
    commit && frame_addr == ADDR_INCR && !link_word_r[INCR_DIR_BIT] |=> duty_r[1] <= $past(duty_r[1]);
  endproperty
  a_step_down: assert property (p_step_down) else $error("step down wrapped");

  property p_ext_untouched;
    @(posedge clk_sys_in) disable iff (rst_in)
    commit && frame_addr == ADDR_INCR |=> $stable(duty_r[NUM_CH-1]) && $stable(gduty_r);
  endproperty
  a_ext_untouched: assert property (p_ext_untouched) else $error("step frame changed ch6 or shared");

  property p_out_ctrl_on;
    @(posedge clk_sys_in) disable iff (rst_in)
    commit && frame_addr == ADDR_OUT_CTRL |=> on_r == $past(link_word_r[NUM_CH-1:0]);
  endproperty
  a_out_ctrl_on: assert property (p_out_ctrl_on) else $error("register 8 did not set on bits");

endmodule

`default_nettype wire

// >>> verif/host_frame_model.sv
/*
  Host side frame source: one 16-bit word per command with a short link
  clock burst. Assumes the unit captures the word on a link edge with done.
*/
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
  output logic        clk_link_out,   // Burst only, idle low
  output logic [15:0] frame_word_out, // Command word
  output logic        frame_done_out  // Frame end strobe
);
  // ****************
  // Frame send
  // ****************
  initial begin
    clk_link_out = 1'b0;
    frame_word_out = 16'h0000;
    frame_done_out = 1'b0;
  end
  // Word held over the edge, then inverted so no stale value lingers
  task automatic send(input logic [15:0] w);
    frame_word_out = w;
    frame_done_out = 1'b1;
    #3 clk_link_out = 1'b1;
    // Release rides the capturing edge, so the sample still sees the word
    frame_done_out <= 1'b0;
    frame_word_out <= ~w;
    #3 clk_link_out = 1'b0;
    #1000; // Frame gap
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
  Self-checking bench for the PWM dimming unit: frames come from the host
  model, reference clock is stopped first then run at 100 kHz.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in, rst_in, ref_clock_in, fail_mode_in, ref_run;
  logic [3:0] pin;
  logic [5:0] pwr, st;
  logic [4:0] win;
  logic fail, lclk, done;
  logic [15:0] word;
  int n_errors, checks, i, win_seen, win_mark;
  // ****************
  // Clocks and parts
  // ****************
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    ref_clock_in = 1'b0;
    forever #5000 if (ref_run) ref_clock_in = ~ref_clock_in;
  end
  host_frame_model host (.clk_link_out(lclk), .frame_word_out(word), .frame_done_out(done));
  // Small loss count keeps the stopped-clock phase short
  pwm_dimming_unit #(.SLOW_CYCLES(2000)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .clk_link_in(lclk), .frame_word_in(word), .frame_done_in(done), .ref_clock_in(ref_clock_in),
    .fail_mode_in(fail_mode_in), .filtered_control_pin_in(pin), .power_output_out(pwr),
    .window_start_out(win), .channel_state_out(st), .ref_clock_fail_out(fail));
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cycles with the channel 5 window pulse high
  always @(posedge clk_sys_in) if (win[4]) win_seen <= win_seen + 1;
  // Bounded wait; running out counts a mismatch and jumps to the report
  task automatic wait_fail(input logic want);
    for (i = 0; i < 40000 && fail !== want; i++) @(negedge clk_sys_in);
    if (fail !== want) begin
      n_errors++;
      disable run_seq;
    end
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    rst_in = 1'b1;
    ref_run = 1'b0;
    fail_mode_in = 1'b0;
    pin = 4'h0;
    n_errors = 0;
    checks = 0;
    repeat (5) @(negedge clk_sys_in);
    rst_in = 1'b0;
    begin : run_seq
      wait_fail(1'b1);
      chk({5'h0, fail}, 6'h01);
      host.send(16'h2110);
      chk(st, 6'h01);
      chk(pwr, 6'h01);
      host.send(16'h802a);
      chk(st, 6'h2a);
      host.send(16'hb0c4);
      chk(st, 6'h28);
      @(negedge clk_sys_in);
      pin = 4'h2;
      repeat (4) @(negedge clk_sys_in);
      chk(st, 6'h2a);
      fail_mode_in = 1'b1;
      pin = 4'hd;
      repeat (4) @(negedge clk_sys_in);
      chk(pwr & 6'h30, 6'h00);
      chk(st, 6'h0d);
      fail_mode_in = 1'b0;
      pin = 4'h0;
      ref_run = 1'b1;
      wait_fail(1'b0);
      chk({5'h0, fail}, 6'h00);
      host.send(16'h8000);
      chk(pwr, 6'h00);
      host.send(16'h41ff);
      chk(pwr, 6'h04);
      host.send(16'h99ff);
      host.send(16'h9008);
      host.send(16'h5100);
      chk(pwr, 6'h0c);
      host.send(16'h61f0);
      host.send(16'he700);
      repeat (50) @(negedge clk_sys_in);
      chk(pwr, 6'h1c);
      host.send(16'he3cc);
      host.send(16'h8000);
      chk(pwr, 6'h00);
      host.send(16'hcc00);
      win_mark = win_seen;
      host.send(16'h6100);
      host.send(16'h7100);
      chk(st, 6'h30);
      chk(pwr, 6'h00);
      chk(6'(win_seen - win_mark), 6'h01);
      // Let the divide-by-4 count leave zero so the sync starts a period
      repeat (5000) @(negedge clk_sys_in);
      host.send(16'h1002);
      chk(pwr & 6'h10, 6'h10);
      repeat (2000) @(negedge clk_sys_in);
      chk(pwr, 6'h10);
      repeat (3000) @(negedge clk_sys_in);
      chk(pwr, 6'h00);
    end
    summarize();
  end
endmodule
`default_nettype wire
